// ===== rtl/rdirq_flag_reg.sv
// Sticky flag register with a set/clear write scheme.
// Assumes the write strobe is a single cycle per bus access.
`timescale 1ns/10ps
`default_nettype none
module rdirq_flag_reg import rdirq_pkg::*; #(
    parameter int W = N0
) (
    // Clock, reset and enable
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_ce,
    // Software write
    input wire logic i_wr,
    input wire logic [REG_W-1:0] i_wdata,
    // Hardware events
    input wire logic [W-1:0] i_hw_set,
    // Flags
    output logic [W-1:0] o_flags
);

    // ==========================================================
    // One flop per flag
    // Hardware set wins over a software clear in the same cycle
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic sw_set;
            logic sw_clr;
            assign sw_set = i_wr & i_wdata[SET_BIT] & i_wdata[g];
            assign sw_clr = i_wr & ~i_wdata[SET_BIT] & i_wdata[g];
            always_ff @(posedge i_clk_sys) begin
                if (i_rst) begin
                    o_flags[g] <= 1'b0;
                end else if (i_ce) begin
                    o_flags[g] <= (o_flags[g] & ~sw_clr) | sw_set |
                        i_hw_set[g];
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// ===== rtl/rdirq_pkg.sv
// Constants, field positions and carrier types for the reader
// interrupt aggregator. Assumes a single 25 MHz system clock.
package rdirq_pkg;

    // ==========================================================
    // Bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int IDX_W = ADDR_W - 2;

    // ==========================================================
    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_FLAGS0 = 10'h006;
    localparam logic [IDX_W-1:0] IDX_FLAGS1 = 10'h007;
    localparam logic [IDX_W-1:0] IDX_EN0 = 10'h008;
    localparam logic [IDX_W-1:0] IDX_EN1 = 10'h009;
    localparam logic [IDX_W-1:0] IDX_EV_STATUS = 10'h010;
    localparam logic [IDX_W-1:0] IDX_EV_MASK = 10'h011;

    // ==========================================================
    // Reset values
    localparam logic [REG_W-1:0] RST_REG = 8'h00;
    localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

    // ==========================================================
    // Flag register layouts
    localparam int N0 = 7;
    localparam int N1 = 6;
    localparam int SET_BIT = 7;
    localparam int GLOBAL_BIT = 6;
    localparam int CARD_BIT = 5;
    localparam int N_TIMER = 5;
    localparam int HI_BIT = 6;
    localparam int IDLE_BIT = 4;
    localparam int ERR_BIT = 1;
    localparam int N_ERR = 5;

    // Enable register control bits
    localparam int INV_BIT = 7;
    localparam int PUSH_PULL_BIT = 7;
    localparam int PIN_GATE_BIT = 6;

    // ==========================================================
    // Block event status and mask layout
    localparam int N_EV = 4;
    localparam int EV_GLOBAL_RISE = 0;
    localparam int EV_ERROR = 1;
    localparam int EV_TIMER = 2;
    localparam int EV_CARD = 3;

    // ==========================================================
    // Event sources from the reader core
    typedef struct packed {
        logic high_alert;
        logic low_alert;
        logic cmd_self_end;
        logic cmd_unknown;
        logic host_idle_cmd;
        logic transmit_done;
        logic receive_done;
        logic [N_ERR-1:0] err_ind;
        logic frame_start;
        logic card_detect;
        logic [N_TIMER-1:0] timer_underflow;
    } rdirq_src_t;

    // Interrupt pin as driven level and output enable
    typedef struct packed {
        logic level;
        logic oe;
    } rdirq_pin_t;

endpackage

// ===== rtl/rdirq_top.sv
// Reader interrupt aggregator: flag registers, enables, pin driver.
// Assumes APB master on i_clk_sys and synchronous event inputs.
//
// What this block does
// [RL1] Top bit one: written ones set flags
// [RL2] Top bit zero: written ones clear flags
// [RL3] Global flag when any enabled flag set
// [RL4] Card detection sets card-detect flag
// [RL5] Timer underflow sets that timer's flag
// [RL6] Invert bit inverts interrupt pin level
// [RL7] First enables gate first flags globally
// [RL8] Second enables gate card/timer flags globally
// [RL9] Drive mode bit: push-pull else open-drain
// [RL10] Pin gate bit passes global to pin
// [RL11] First flags use same set/clear writes
// [RL12] Idle flag on self end, not host
// [RL13] Any error indication sets error flag
// [RL14] Open-drain drives only while request active
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module rdirq_top import rdirq_pkg::*; (
    // Clock, reset and enable
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_ce,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [DATA_W-1:0] i_pwdata,
    output logic o_pready,
    output logic [DATA_W-1:0] o_prdata,
    output logic o_pslverr,
    // Event sources
    input wire rdirq_src_t i_src,
    // Interrupt pin
    output var rdirq_pin_t o_pin,
    // System interrupt
    output logic o_irq
);

    // ==========================================================
    // Bus decode
    logic captured;
    logic wr_fire;
    logic [IDX_W-1:0] idx;
    logic aligned;
    logic [REG_W-1:0] wbyte;

    assign idx = i_paddr[ADDR_W-1:2];
    assign aligned = (i_paddr[1:0] == 2'h0);
    assign wbyte = i_pwdata[REG_W-1:0];
    // Answer one cycle after setup unless frozen by the enable
    assign o_pready = i_ce & i_psel & i_penable & captured;
    assign wr_fire = o_pready & i_pwrite;

    // ==========================================================
    // Enable registers
    logic [REG_W-1:0] first_interrupt_enables;
    logic [REG_W-1:0] second_interrupt_enables;
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            first_interrupt_enables <= RST_REG;
        end else if (i_ce && wr_fire && aligned && idx == IDX_EN0) begin
            first_interrupt_enables <= wbyte;
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            second_interrupt_enables <= RST_REG;
        end else if (i_ce && wr_fire && aligned && idx == IDX_EN1) begin
            second_interrupt_enables <= wbyte;
        end
    end

    // ==========================================================
    // Event conditioning
    // Error indications are levels; only their rising edge counts
    logic [N_ERR-1:0] err_prev;
    logic [N_ERR-1:0] err_rise;
    logic [N0-1:0] hw_set0;
    logic [N1-1:0] hw_set1;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            err_prev <= '0;
        end else if (i_ce) begin
            err_prev <= i_src.err_ind;
        end
    end

    assign err_rise = i_src.err_ind & ~err_prev;

    // Host-issued idle is deliberately not a source here
    assign hw_set0 = {
        i_src.high_alert,
        i_src.low_alert,
        i_src.cmd_self_end | i_src.cmd_unknown, // see [RL12]
        i_src.transmit_done,
        i_src.receive_done,
        |err_rise, // see [RL13]
        i_src.frame_start
    };
    // see [RL4] see [RL5]
    assign hw_set1 = {i_src.card_detect, i_src.timer_underflow};

    // ==========================================================
    // Flag registers
    logic [N0-1:0] first_interrupt_flags;
    logic [N1-1:0] second_interrupt_flags;
    logic wr0;
    logic wr1;
    assign wr0 = wr_fire & aligned & (idx == IDX_FLAGS0);
    assign wr1 = wr_fire & aligned & (idx == IDX_FLAGS1);
    rdirq_flag_reg #(.W(N0)) u_flags0 ( // see [RL11]
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_wr(wr0),
        .i_wdata(wbyte),
        .i_hw_set(hw_set0),
        .o_flags(first_interrupt_flags)
    );
    rdirq_flag_reg #(.W(N1)) u_flags1 ( // see [RL1] see [RL2]
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_wr(wr1),
        .i_wdata(wbyte),
        .i_hw_set(hw_set1),
        .o_flags(second_interrupt_flags)
    );

    // ==========================================================
    // Global request
    logic any_enabled_request;

    assign any_enabled_request =
        (|(first_interrupt_flags & first_interrupt_enables[N0-1:0])) |
        (|(second_interrupt_flags & second_interrupt_enables[N1-1:0]));
    // see [RL3] see [RL7] see [RL8]

    // ==========================================================
    // Interrupt pin driver
    logic pin_active;
    logic pin_level;
    logic pin_drive_mode;

    assign pin_active = any_enabled_request &
        second_interrupt_enables[PIN_GATE_BIT]; // see [RL10]
    assign pin_level = pin_active ^
        first_interrupt_enables[INV_BIT]; // see [RL6]
    assign pin_drive_mode = second_interrupt_enables[PUSH_PULL_BIT];

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_pin <= '0;
        end else if (i_ce) begin
            o_pin.level <= pin_level;
            // Open drain releases the wire when idle
            o_pin.oe <= pin_drive_mode | pin_active; // see [RL9] see [RL14]
        end
    end

    // ==========================================================
    // Block event status, mask and system interrupt
    logic any_prev;
    logic [N_EV-1:0] ev;
    logic [N_EV-1:0] ev_status;
    logic [N_EV-1:0] ev_mask;
    logic [N_EV-1:0] ev_clr;
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            any_prev <= 1'b0;
        end else if (i_ce) begin
            any_prev <= any_enabled_request;
        end
    end
    assign ev[EV_GLOBAL_RISE] = any_enabled_request & ~any_prev;
    assign ev[EV_ERROR] = |err_rise;
    assign ev[EV_TIMER] = |i_src.timer_underflow;
    assign ev[EV_CARD] = i_src.card_detect;
    assign ev_clr = (wr_fire && aligned && idx == IDX_EV_STATUS) ?
        i_pwdata[N_EV-1:0] : '0;
    // New events win over a write-one-to-clear in the same cycle
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ev_status <= '0;
        end else if (i_ce) begin
            ev_status <= (ev_status & ~ev_clr) | ev;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ev_mask <= '0;
        end else if (i_ce && wr_fire && aligned && idx == IDX_EV_MASK) begin
            ev_mask <= i_pwdata[N_EV-1:0];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else if (i_ce) begin
            o_irq <= |(ev_status & ev_mask);
        end
    end

    // ==========================================================
    // Read path
    // Read data is sampled when the request is first seen, so a
    // flag that sets during a stalled access shows on the next read
    logic [DATA_W-1:0] next_rdata;
    logic next_err;

    always_comb begin
        next_rdata = RD_ZERO;
        next_err = 1'b0;
        if (!aligned) begin
            next_err = 1'b1;
        end else begin
            case (idx)
                IDX_FLAGS0: begin
                    next_rdata[N0-1:0] = first_interrupt_flags;
                end
                IDX_FLAGS1: begin
                    next_rdata[N1-1:0] = second_interrupt_flags;
                    next_rdata[GLOBAL_BIT] = any_enabled_request;
                end
                IDX_EN0: begin
                    next_rdata[REG_W-1:0] = first_interrupt_enables;
                end
                IDX_EN1: begin
                    next_rdata[REG_W-1:0] = second_interrupt_enables;
                end
                IDX_EV_STATUS: begin
                    next_rdata[N_EV-1:0] = ev_status;
                end
                IDX_EV_MASK: begin
                    next_rdata[N_EV-1:0] = ev_mask;
                end
                default: begin
                    next_err = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            captured <= 1'b0;
        end else if (i_ce) begin
            if (o_pready) begin
                captured <= 1'b0;
            end else if (i_psel) begin
                captured <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_prdata <= RD_ZERO;
            o_pslverr <= 1'b0;
        end else if (i_ce && i_psel && !captured) begin
            o_prdata <= i_pwrite ? RD_ZERO : next_rdata;
            o_pslverr <= next_err;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);
    logic [N1-1:0] wmask1;
    assign wmask1 = wbyte[N1-1:0];
    sequence s_set_write1;
        i_ce && wr1 && wbyte[SET_BIT];
    endsequence
    sequence s_clr_write1;
        i_ce && wr1 && !wbyte[SET_BIT] && ((hw_set1 & wmask1) == '0);
    endsequence
    property p_set_write1;
        s_set_write1 |=> ((second_interrupt_flags & $past(wmask1)) ==
            $past(wmask1));
    endproperty
    a_set_write1: assert property (p_set_write1) // see [RL1]
        else $error("set write did not set flags");
    property p_clr_write1;
        s_clr_write1 |=> ((second_interrupt_flags & $past(wmask1)) == '0);
    endproperty
    a_clr_write1: assert property (p_clr_write1) // see [RL2]
        else $error("clear write did not clear flags");
    property p_global;
        i_ce && i_src.card_detect && second_interrupt_enables[CARD_BIT]
            && !wr_fire |=> any_enabled_request;
    endproperty
    a_global: assert property (p_global) // see [RL3]
        else $error("enabled flag did not raise global request");
    property p_card;
        i_ce && i_src.card_detect |=> second_interrupt_flags[CARD_BIT];
    endproperty
    a_card: assert property (p_card) // see [RL4]
        else $error("card detect flag not set");
    property p_timer;
        i_ce && (|i_src.timer_underflow) |=>
            ((second_interrupt_flags[N_TIMER-1:0] &
            $past(i_src.timer_underflow)) == $past(i_src.timer_underflow));
    endproperty
    a_timer: assert property (p_timer) // see [RL5]
        else $error("timer underflow flag not set");
    property p_invert;
        i_ce && pin_drive_mode |=>
            o_pin.level == ($past(pin_active) ^
            $past(first_interrupt_enables[INV_BIT]));
    endproperty
    a_invert: assert property (p_invert) // see [RL6]
        else $error("pin level wrong for invert setting");
    sequence s_alert_seen;
        i_ce && i_src.high_alert && first_interrupt_enables[HI_BIT]
            && !wr_fire;
    endsequence
    property p_alert_gate;
        s_alert_seen |=> any_enabled_request;
    endproperty
    a_alert_gate: assert property (p_alert_gate) // see [RL7]
        else $error("enabled alert did not reach global request");
    property p_push_pull;
        i_ce && pin_drive_mode |=> o_pin.oe;
    endproperty
    a_push_pull: assert property (p_push_pull) // see [RL9]
        else $error("push-pull pin not driven");
    property p_pin_gate;
        i_ce && !second_interrupt_enables[PIN_GATE_BIT] && !pin_drive_mode
            |=> !o_pin.oe;
    endproperty
    a_pin_gate: assert property (p_pin_gate) // see [RL10]
        else $error("pin driven while pin gate is off");
    property p_flags0_all;
        i_ce && wr0 && wbyte == 8'hff |=> first_interrupt_flags == 7'h7f;
    endproperty
    a_flags0_all: assert property (p_flags0_all) // see [RL11]
        else $error("writing all ones did not set first flags");
    property p_host_idle;
        i_ce && i_src.host_idle_cmd && !i_src.cmd_self_end &&
            !i_src.cmd_unknown && !first_interrupt_flags[IDLE_BIT] && !wr0
            |=> !first_interrupt_flags[IDLE_BIT];
    endproperty
    a_host_idle: assert property (p_host_idle) // see [RL12]
        else $error("host idle command set idle flag");
    property p_error;
        i_ce && (|err_rise) |=> first_interrupt_flags[ERR_BIT];
    endproperty
    a_error: assert property (p_error) // see [RL13]
        else $error("error indication did not set error flag");
    property p_open_drain;
        i_ce && !pin_drive_mode |=> o_pin.oe == $past(pin_active);
    endproperty
    a_open_drain: assert property (p_open_drain) // see [RL14]
        else $error("open-drain enable does not follow request");

endmodule
`default_nettype wire

// ===== sim/rdirq_bench.sv
// Self-checking bench for the reader interrupt aggregator.
// Assumes the host model drives APB; events come straight from here.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module rdirq_bench import rdirq_pkg::*;;
    logic clk, rst, ce, psel, penable, pwrite, pready, pslverr, irq, pin_wire;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, q, r;
    logic e;
    rdirq_src_t src, s;
    rdirq_pin_t pin;
    logic [ADDR_W-1:0] adr [6];
    logic [6:0] f0;
    logic [5:0] f1;
    logic [7:0] en0, en1;
    logic [3:0] ev, msk;
    logic g_prev;
    int mismatches, num_checks, seed, cyc, i;

    rdirq_top u_rdirq_top (.i_clk_sys(clk), .i_rst(rst), .i_ce(ce),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
        .o_prdata(prdata), .o_pslverr(pslverr), .i_src(src),
        .o_pin(pin), .o_irq(irq));
    rdirq_host u_rdirq_host (.i_clk_sys(clk), .o_psel(psel),
        .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
        .o_pwdata(pwdata), .i_pready(pready), .i_prdata(prdata),
        .i_pslverr(pslverr), .i_pin(pin), .o_pin_wire(pin_wire));

    always #20 clk = ~clk;

    // ==========================================================
    // Model of the flag logic
    function automatic logic glob();
        return |(f0 & en0[6:0]) |
            |(f1 & en1[5:0]);
    endfunction

    // Rise of the global request only; a level would re-set after W1C
    task automatic upd_rise();
        if (glob() && !g_prev) ev[EV_GLOBAL_RISE] = 1'b1;
        g_prev = glob();
    endtask

    task automatic do_write(input int k, input logic [7:0] d);
        u_rdirq_host.xfer(1'b1, adr[k], {24'h0, d}, q, e);
        case (k)
            0: f0 = d[7] ? f0 | d[6:0] : f0 & ~d[6:0];
            1: f1 = d[7] ? f1 | d[5:0] : f1 & ~d[5:0];
            2: en0 = d;
            3: en1 = d;
            4: ev = ev & ~d[3:0];
            default: msk = d[3:0];
        endcase
        upd_rise();
    endtask

    task automatic do_event(input rdirq_src_t t);
        @(posedge clk);
        src <= t;
        @(posedge clk);
        src <= '0;
        f0 = f0 | {t.high_alert, t.low_alert, t.cmd_self_end | t.cmd_unknown,
            t.transmit_done, t.receive_done, |t.err_ind, t.frame_start};
        f1 = f1 | {t.card_detect, t.timer_underflow};
        ev = ev | {t.card_detect, |t.timer_underflow, |t.err_ind, 1'b0};
        upd_rise();
    endtask

    task automatic check_all();
        rdirq_pin_t ep;
        ep.level = (glob() & en1[PIN_GATE_BIT]) ^ en0[INV_BIT];
        ep.oe = en1[PUSH_PULL_BIT] | (glob() & en1[PIN_GATE_BIT]);
        repeat (3) @(posedge clk);
        #1;
        `CHK(pin, ep)
        `CHK(pin_wire, ep.oe ? ep.level : 1'b1)
        `CHK(irq, |(ev & msk))
        u_rdirq_host.xfer(1'b0, adr[0], 32'h0, q, e);
        `CHK(q, {25'h0, f0})
        u_rdirq_host.xfer(1'b0, adr[1], 32'h0, q, e);
        `CHK(q, {25'h0, glob(), f1})
        u_rdirq_host.xfer(1'b0, adr[2], 32'h0, q, e);
        `CHK(q, {24'h0, en0})
        u_rdirq_host.xfer(1'b0, adr[3], 32'h0, q, e);
        `CHK(q, {24'h0, en1})
        u_rdirq_host.xfer(1'b0, adr[4], 32'h0, q, e);
        `CHK(q, {28'h0, ev})
        u_rdirq_host.xfer(1'b0, adr[5], 32'h0, q, e);
        `CHK(q, {28'h0, msk})
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // ==========================================================
    // Hang guard, far above the few thousand cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            mismatches++;
            give_verdict();
        end
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        src = '0;
        seed = 80;
        cyc = 0;
        mismatches = 0;
        num_checks = 0;
        {f0, f1, en0, en1, ev, msk, g_prev} = '0;
        adr[0] = {IDX_FLAGS0, 2'b00};
        adr[1] = {IDX_FLAGS1, 2'b00};
        adr[2] = {IDX_EN0, 2'b00};
        adr[3] = {IDX_EN1, 2'b00};
        adr[4] = {IDX_EV_STATUS, 2'b00};
        adr[5] = {IDX_EV_MASK, 2'b00};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        check_all();
        // Unmapped and unaligned places are refused and change nothing
        u_rdirq_host.xfer(1'b1, 12'h100, 32'hff, q, e);
        `CHK(e, 1'b1)
        u_rdirq_host.xfer(1'b0, adr[0] + 12'h001, 32'h0, q, e);
        `CHK(e, 1'b1)
        `CHK(q, RD_ZERO)
        do_write(0, 8'hff);
        check_all();
        do_write(0, 8'h7f);
        check_all();
        s = '0;
        s.host_idle_cmd = 1'b1;
        do_event(s);
        check_all();
        for (i = 0; i < 90; i++) begin
            r = $random(seed);
            if (r[2:1] == 2'b00) do_event(rdirq_src_t'(r[31:13]));
            else do_write(int'(r[10:8]) % 6, r[7:0]);
            check_all();
        end
        // Frozen enable: a pulse on every source must change nothing
        @(posedge clk);
        ce <= 1'b0;
        src <= '1;
        @(posedge clk);
        ce <= 1'b1;
        src <= '0;
        check_all();
        // Mid-run reset returns every register to zero
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        {f0, f1, en0, en1, ev, msk, g_prev} = '0;
        check_all();
        give_verdict();
    end
endmodule
`default_nettype wire

// ===== sim/rdirq_host.sv
// Host controller model: APB master and the board side of the irq pin.
// Assumes a pull-up on the irq wire and one clock shared with the block.
`timescale 1ns/10ps
`default_nettype none
module rdirq_host import rdirq_pkg::*; (
    // Clock
    input wire logic i_clk_sys,
    // APB master
    output logic o_psel,
    output logic o_penable,
    output logic o_pwrite,
    output logic [ADDR_W-1:0] o_paddr,
    output logic [DATA_W-1:0] o_pwdata,
    input wire logic i_pready,
    input wire logic [DATA_W-1:0] i_prdata,
    input wire logic i_pslverr,
    // Interrupt pin
    input wire rdirq_pin_t i_pin,
    output logic o_pin_wire
);
    // ==========================================================
    // Wire level
    // Released pin floats to the pull-up, never to the last level
    assign o_pin_wire = i_pin.oe ? i_pin.level : 1'b1;

    initial begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = '0;
        o_pwdata = '0;
    end

    // ==========================================================
    // One APB transfer; waits for pready as long as it takes, so only
    // the bench timeout ends a hung slave
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] q, output logic e);
        @(posedge i_clk_sys);
        o_psel <= 1'b1;
        o_penable <= 1'b0;
        o_pwrite <= w;
        o_paddr <= a;
        o_pwdata <= d;
        @(posedge i_clk_sys);
        o_penable <= 1'b1;
        // Looked at mid-cycle: pready and read data have settled there
        // and stand unchanged until the edge that completes the access
        @(negedge i_clk_sys);
        while (i_pready !== 1'b1) begin
            @(negedge i_clk_sys);
        end
        q = i_prdata;
        e = i_pslverr;
        @(posedge i_clk_sys);
        o_psel <= 1'b0;
        o_penable <= 1'b0;
    endtask
endmodule
`default_nettype wire
